// ==== dv/sdd_ctrl_model.sv ====
`timescale 1ns/10ps
module sdd_ctrl_model
(
   input wire logic i_clk_sys,
   output logic o_shift_clk,
   output logic o_serial_in,
   output logic o_latch_strobe,
   output logic o_output_force_low
);
   initial
   begin
      o_shift_clk = 1'b0;
      o_serial_in = 1'b0;
      o_latch_strobe = 1'b0;
      o_output_force_low = 1'b0;
   end
   // Top bit first; the data line turns over after the frame so late sampling shows
   task automatic shift_word(input logic [19:0] w, input int n, input int low);
      for (int i = n - 1; i >= 0; i--)
      begin
         o_shift_clk <= 1'b0;
         o_serial_in <= w[i];
         repeat (low) @(posedge i_clk_sys);
         o_shift_clk <= 1'b1;
         @(posedge i_clk_sys);
      end
      o_shift_clk <= 1'b0;
      o_serial_in <= ~w[0];
      @(posedge i_clk_sys);
   endtask : shift_word
   // Long wait lets a backed-up queue drain before the commit
   task automatic latch();
      repeat (60) @(posedge i_clk_sys);
      o_latch_strobe <= 1'b1;
      @(posedge i_clk_sys);
      o_latch_strobe <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
   endtask : latch
   task automatic set_force(input logic v);
      o_output_force_low <= v;
      repeat (4) @(posedge i_clk_sys);
   endtask : set_force
   // Holding the strobe high keeps the latch transparent while shifting
   task automatic set_strobe(input logic v);
      o_latch_strobe <= v;
      repeat (4) @(posedge i_clk_sys);
   endtask : set_strobe
endmodule : sdd_ctrl_model

// ==== dv/sdd_top_props.sv ====
`timescale 1ns/10ps
module sdd_top_props
#(
   parameter int unsigned WIDTH = 20
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_shift_clk,
   input wire logic i_serial_in,
   input wire logic i_latch_strobe,
   input wire logic i_output_force_low,
   input wire logic [WIDTH-1:0] o_driver_output,
   input wire logic o_serial_out,
   input wire logic o_shift_overrun
);
   logic prev_clk;
   logic [5:0] quiet;
   // Saturating count of cycles since the last shift clock rise; 63 outlasts a full queue
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         prev_clk <= 1'b0;
         quiet <= 6'h00;
      end
      else
      begin
         prev_clk <= i_shift_clk;
         quiet <= (i_shift_clk && !prev_clk) ? 6'h00 : quiet + 6'((quiet != 6'h3F));
      end
   end
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   a_force_low_zero: assert property (i_output_force_low |-> ##2 o_driver_output == '0)
      else $error("driver outputs not low while forced");
   a_hold_closed: assert property ((!i_latch_strobe && !i_output_force_low)[*4]
      |-> $stable(o_driver_output)) else $error("outputs moved with latch closed");
   a_quiet_serial: assert property (quiet == 6'h3F |-> $stable(o_serial_out))
      else $error("serial output moved without a shift");
   a_cascade_seen: assert property ((i_latch_strobe && !i_output_force_low)[*3]
      ##0 quiet == 6'h3F |-> o_driver_output[WIDTH-1] == o_serial_out)
      else $error("last output differs from serial output");
   a_overrun_sticky: assert property (o_shift_overrun |=> o_shift_overrun)
      else $error("overrun flag dropped");
   a_overrun_cause: assert property ($rose(o_shift_overrun) |-> quiet < 6'h06)
      else $error("overrun without a recent shift edge");
endmodule : sdd_top_props

bind sdd_top sdd_top_props #(.WIDTH(WIDTH)) sdd_top_props_inst (.i_clk_sys, .i_rst,
   .i_shift_clk, .i_serial_in, .i_latch_strobe, .i_output_force_low, .o_driver_output,
   .o_serial_out, .o_shift_overrun);

// ==== dv/sdd_top_test.sv ====
`timescale 1ns/10ps
module sdd_top_test;
   logic i_clk_sys;
   logic i_rst;
   logic sclk, sdat, lat, frc, sout, ovr;
   logic [19:0] dout;
   int num_errors = 0;
   int tests_run = 0;
   logic [19:0] w1 = 20'hA5C3F;
   logic [19:0] w2 = 20'h5A3C0;
   sdd_top #(.GAP_CYC(4)) sdd_top_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_shift_clk(sclk), .i_serial_in(sdat), .i_latch_strobe(lat),
      .i_output_force_low(frc), .o_driver_output(dout), .o_serial_out(sout),
      .o_shift_overrun(ovr));
   sdd_ctrl_model sdd_ctrl_model_inst (.i_clk_sys(i_clk_sys), .o_shift_clk(sclk),
      .o_serial_in(sdat), .o_latch_strobe(lat), .o_output_force_low(frc));
   initial
   begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   task automatic t_word();
      sdd_ctrl_model_inst.shift_word(w1, 20, 3);
      repeat (60) @(posedge i_clk_sys);
      check(dout, 20'h00000);
      sdd_ctrl_model_inst.latch();
      check(dout, w1);
      check(20'(sout), 20'(w1[19]));
      $display("word load done");
   endtask : t_word
   task automatic t_hold();
      sdd_ctrl_model_inst.shift_word(w2, 20, 3);
      repeat (60) @(posedge i_clk_sys);
      check(dout, w1);
      check(20'(sout), 20'(w2[19]));
      $display("hold done");
   endtask : t_hold
   task automatic t_force();
      sdd_ctrl_model_inst.set_force(1'b1);
      sdd_ctrl_model_inst.latch();
      check(dout, 20'h00000);
      sdd_ctrl_model_inst.set_force(1'b0);
      check(dout, w2);
      $display("force low done");
   endtask : t_force
   task automatic t_step();
      sdd_ctrl_model_inst.shift_word(20'h00001, 1, 3);
      sdd_ctrl_model_inst.latch();
      check(dout, {w2[18:0], 1'b1});
      check(20'(sout), 20'(w2[18]));
      $display("single shift done");
   endtask : t_step
   task automatic t_overrun();
      check(20'(ovr), 20'h00000);
      sdd_ctrl_model_inst.shift_word(20'hFFFFF, 20, 1);
      sdd_ctrl_model_inst.shift_word(20'hFFFFF, 20, 1);
      check(20'(ovr), 20'h00001);
      sdd_ctrl_model_inst.shift_word(w1, 20, 3);
      sdd_ctrl_model_inst.latch();
      check(dout, w1);
      check(20'(ovr), 20'h00001);
      $display("queue overrun done");
   endtask : t_overrun
   task automatic t_transparent();
      sdd_ctrl_model_inst.set_strobe(1'b1);
      sdd_ctrl_model_inst.shift_word(w2 >> 10, 10, 3);
      repeat (10) @(posedge i_clk_sys);
      check(dout, {w1[9:0], w2[19:10]});
      sdd_ctrl_model_inst.shift_word(w2, 10, 3);
      repeat (70) @(posedge i_clk_sys);
      check(dout, w2);
      check(20'(sout), 20'(w2[19]));
      sdd_ctrl_model_inst.set_strobe(1'b0);
      check(dout, w2);
      $display("transparent latch done");
   endtask : t_transparent
   initial
   begin
      repeat (20000) @(posedge i_clk_sys);
      num_errors++;
      $display("watchdog expired");
      complete_run();
   end
   initial
   begin
      i_rst = 1'b1;
      repeat (10) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      @(posedge i_clk_sys);
      t_word();
      t_hold();
      t_force();
      t_step();
      t_overrun();
      t_transparent();
      complete_run();
   end
endmodule : sdd_top_test

// ==== hdl/sdd_fifo.sv ====
`timescale 1ns/10ps
module sdd_fifo
#(
   parameter int unsigned WIDTH = 1,
   parameter int unsigned DEPTH = sdd_pkg::FIFO_DEPTH
)
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Filling side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Draining side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);

   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic out_valid;
   logic [WIDTH-1:0] out_data;
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] next_count;
   logic next_out_valid;
   logic [WIDTH-1:0] next_out_data;
   logic push;
   logic load;

   always_comb
   begin
      push = i_in_valid && (count != (AW+1)'(DEPTH));
      // Output register refills whenever storage holds an entry and the register is empty or being taken
      load = (count != '0) && (!out_valid || i_out_ready);
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_out_valid = out_valid && !i_out_ready;
      next_out_data = out_data;
      if (push)
      begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (load)
      begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         next_out_valid = 1'b1;
         next_out_data = mem[rd_ptr];
      end
      next_count = count + (AW+1)'(push) - (AW+1)'(load);
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
      end
   end

   // Storage has no reset; entries are only read after being written
   always_ff @(posedge i_clk_sys)
   begin
      if (push)
      begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   assign o_in_ready = (count != (AW+1)'(DEPTH));
   assign o_out_valid = out_valid;
   assign o_out_data = out_data;

endmodule : sdd_fifo

// ==== hdl/sdd_pin_sampler.sv ====
`timescale 1ns/10ps
module sdd_pin_sampler
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Controller pins
   input wire sdd_pkg::sdd_pins_t i_pins,
   // Sampled pins and shift clock rising edge
   output sdd_pkg::sdd_pins_t o_pins,
   output logic o_shift_edge
);

   sdd_pkg::sdd_pins_t pins;
   logic prev_shift_clk;
   sdd_pkg::sdd_pins_t next_pins;
   logic next_prev_shift_clk;

   always_comb
   begin
      next_pins = i_pins;
      next_prev_shift_clk = pins.shift_clk;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         pins <= sdd_pkg::PINS_RESET;
         prev_shift_clk <= 1'b0;
      end
      else
      begin
         pins <= next_pins;
         prev_shift_clk <= next_prev_shift_clk;
      end
   end

   assign o_pins = pins;
   // Previous sample resets low, so a pin already high at reset release gives one edge
   assign o_shift_edge = pins.shift_clk & ~prev_shift_clk;

endmodule : sdd_pin_sampler

// ==== hdl/sdd_pkg.sv ====
package sdd_pkg;

   // Chain length and buffer depth
   localparam int unsigned STAGE_COUNT = 20;
   localparam int unsigned FIFO_DEPTH = 8;

   // Clock rate and the shortest spacing between two applied shifts
   localparam int unsigned CLK_SYS_HZ = 20000000;
   localparam int unsigned SHIFT_GAP_NS = 50;
   localparam int unsigned SHIFT_GAP_CYC =
      ((SHIFT_GAP_NS * (CLK_SYS_HZ / 1000000)) + 999) / 1000;

   // Position of the shift stage that feeds the serial output
   localparam int unsigned LAST_STAGE = STAGE_COUNT - 1;

   // Values after reset
   localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 20'h00000;
   localparam logic [STAGE_COUNT-1:0] HELD_RESET = 20'h00000;

   // Controller pins, sampled together
   typedef struct packed {
      logic shift_clk;
      logic serial_in;
      logic latch_strobe;
      logic output_force_low;
   } sdd_pins_t;

   localparam sdd_pins_t PINS_RESET = '{shift_clk: 1'b0, serial_in: 1'b0,
                                        latch_strobe: 1'b0, output_force_low: 1'b0};

endpackage : sdd_pkg

// ==== hdl/sdd_top.sv ====
// Overview of operation
// - Each rising edge of the shift clock that finds room in the queue moves the 20-stage register by one place, else it holds.
// - On a shift the first stage takes the serial input and every later stage its predecessor.
// - While the latch strobe is high the held bits follow the shift stages continuously.
// - While the latch strobe is low the held bits keep their value whatever is shifted.
// - While output force low is high all 20 driver outputs are low.
// - While output force low is low each driver output shows the held bit of the same number.
// - The serial output always shows the twentieth shift stage for cascading.
`timescale 1ns/10ps
module sdd_top
#(
   parameter int unsigned WIDTH = sdd_pkg::STAGE_COUNT,
   parameter int unsigned DEPTH = sdd_pkg::FIFO_DEPTH,
   parameter int unsigned GAP_CYC = sdd_pkg::SHIFT_GAP_CYC
)
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Controller pins
   input wire logic i_shift_clk,
   input wire logic i_serial_in,
   input wire logic i_latch_strobe,
   input wire logic i_output_force_low,
   // Display side
   output logic [WIDTH-1:0] o_driver_output,
   output logic o_serial_out,
   // Status
   output logic o_shift_overrun
);

   localparam int unsigned GW = (GAP_CYC > 1) ? $clog2(GAP_CYC) : 1;

   sdd_pkg::sdd_pins_t pins_raw;
   sdd_pkg::sdd_pins_t pins;
   logic shift_edge;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_data;
   logic fifo_out_ready;

   logic [WIDTH-1:0] shift_stage;
   logic [WIDTH-1:0] held_bit;
   logic [WIDTH-1:0] driver_output;
   logic serial_out;
   logic shift_overrun;
   logic [GW-1:0] gap_cnt;
   logic [WIDTH-1:0] next_shift_stage;
   logic [WIDTH-1:0] next_held_bit;
   logic [WIDTH-1:0] next_driver_output;
   logic next_serial_out;
   logic next_shift_overrun;
   logic [GW-1:0] next_gap_cnt;
   logic do_shift;

   always_comb
   begin
      pins_raw.shift_clk = i_shift_clk;
      pins_raw.serial_in = i_serial_in;
      pins_raw.latch_strobe = i_latch_strobe;
      pins_raw.output_force_low = i_output_force_low;
   end

   sdd_pin_sampler u_sampler
   (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_pins(pins_raw),
      .o_pins(pins),
      .o_shift_edge(shift_edge)
   );

   // Shifts are queued so a burst of edges is never dropped while the
   // applying side is paced; only a full queue loses an edge
   sdd_fifo #(.WIDTH(1), .DEPTH(DEPTH)) u_fifo
   (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_in_valid(shift_edge),
      .i_in_data(pins.serial_in),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(fifo_out_valid),
      .o_out_data(fifo_out_data),
      .i_out_ready(fifo_out_ready)
   );

   assign fifo_out_ready = (gap_cnt == '0);
   assign do_shift = fifo_out_valid && fifo_out_ready;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_stage
         if (g == 0)
         begin : g_first
            assign next_shift_stage[g] = do_shift ? fifo_out_data : shift_stage[g];
         end
         else
         begin : g_rest
            assign next_shift_stage[g] = do_shift ? shift_stage[g-1] : shift_stage[g];
         end
         // Forcing low overrides whatever the held bit says
         assign next_driver_output[g] = ~pins.output_force_low & next_held_bit[g];
      end
   endgenerate

   always_comb
   begin
      next_gap_cnt = gap_cnt;
      if (do_shift)
      begin
         next_gap_cnt = GW'(GAP_CYC - 1);
      end
      else if (gap_cnt != '0)
      begin
         next_gap_cnt = gap_cnt - 1'b1;
      end
      next_held_bit = pins.latch_strobe ? shift_stage : held_bit;
      next_serial_out = next_shift_stage[sdd_pkg::LAST_STAGE];
      // Sticky until reset: an edge arriving on a full queue is lost
      next_shift_overrun = shift_overrun | (shift_edge & ~fifo_in_ready);
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         shift_stage <= sdd_pkg::STAGE_RESET;
         held_bit <= sdd_pkg::HELD_RESET;
         driver_output <= '0;
         serial_out <= 1'b0;
         shift_overrun <= 1'b0;
         gap_cnt <= '0;
      end
      else
      begin
         shift_stage <= next_shift_stage;
         held_bit <= next_held_bit;
         driver_output <= next_driver_output;
         serial_out <= next_serial_out;
         shift_overrun <= next_shift_overrun;
         gap_cnt <= next_gap_cnt;
      end
   end

   assign o_driver_output = driver_output;
   assign o_serial_out = serial_out;
   assign o_shift_overrun = shift_overrun;

endmodule : sdd_top
